// ===== rtl/irb_defs.vh
// constants for the rate, bias and command register group
// assumes byte-wide register port, 16-bit registers at even addresses
`ifndef IRB_DEFS_VH
`define IRB_DEFS_VH
`define IRB_ADDR_W          7
`define IRB_ADDR_SCALE      7'h62
`define IRB_ADDR_DECIM      7'h64
`define IRB_ADDR_BIAS       7'h66
`define IRB_ADDR_CMD        7'h68
`define IRB_ADDR_FWREV      7'h6C
`define IRB_RST_SCALE       16'h07D0
`define IRB_RST_DECIM       16'h0000
`define IRB_RST_BIAS        16'h070A
`define IRB_DECIM_MAX       11'h7CF
`define IRB_DECIM_MSB       10
`define IRB_BIAS_MASK       16'h3F0F
`define IRB_TBC_MAX         4'hC
`define IRB_CMD_RESET       7
`define IRB_CMD_FTEST       4
`define IRB_CMD_BACKUP      3
`define IRB_CMD_SELFTEST    2
`define IRB_CMD_RESTORE     1
`define IRB_CMD_BIASUPD     0
`define IRB_MODE_INT        3'h0
`define IRB_MODE_DIRECT     3'h1
`define IRB_MODE_SCALED     3'h2
`define IRB_MODE_OUTPUT     3'h3
`define IRB_MODE_PULSE      3'h5
// base sample rate 2000 Hz from 50 MHz: 25000 cycles
`define IRB_BASE_HZ         2000
`define IRB_CLK_HZ          50000000
`define IRB_BASE_DIV        (`IRB_CLK_HZ / `IRB_BASE_HZ)
`define IRB_DIAG_FTEST      6
`define IRB_DIAG_SELFTEST   5
`define IRB_DIAG_BACKUP     2
`endif

// ===== rtl/irb_regs.v
// rate, bias estimator and global command registers of the inertial unit
// assumes a byte write/read port decoded from the serial host, synchronous
// inputs, and external engines that report command completion and results
// Notes on behaviour
// RL1: decimation uses bits 10:0, capped at 1999; upper five bits are ignored.
// RL2: internal clock mode output rate is 2000 over decimation plus one.
// RL3: samples are averaged per output period; delta interval stretches too.
// RL4: scaled mode rate is sync frequency times scale factor over decimation+1.
// RL5: direct and pulse modes use scale factor one.
// RL6: bias config bits 13:11 accel Z,Y,X; bits 10:8 gyro Z,Y,X enables.
// RL7: time base exponent bits 3:0 ranges 0 to 12; averaging is 64 bases.
// RL8: bias config resets to 0x070A: gyros on, accels off, exponent ten.
// RL9: a written one starts a command: 7,4,3,2,1,0 as listed.
// RL10: while a command runs, no data, no data ready, host requests ignored.
// RL11: software reset clears data and restarts, like the reset pin; here the diagnostic flags keep their values.
// RL12: flash test compares a checksum and sets diagnostic bit six on mismatch.
// RL13: flash backup stores user registers; diagnostic bit two shows failure.
// RL14: self test applies stimulus, compares change, reports diagnostic bit five.
// RL15: factory restore defaults control, decimation, filter; zeroes twelve offsets.
// RL16: bias update applies estimator corrections to sensor outputs.
// RL17: firmware revision is a sixteen-bit four-digit decimal-coded value.
// RL18: timing mode code 000 internal, 001 direct, 010 scaled, 011 output, 101 pulse.
// RL19: scaled mode sync input runs 1 to 128 Hz, sample clock multiplied.
// RL20: host writes low byte to even address, then high byte to odd.
// RL21: command bits hold no state; pending command clears on completion.
`timescale 1ns/1ns
`include "irb_defs.vh"
module irb_regs #(
    parameter [15:0] FW_REVISION = 16'h0100,  // arbitrary value
    parameter [31:0] BASE_DIV    = `IRB_BASE_DIV
) (
    input  wire        i_ref_clk,
    input  wire        i_reset,
    input  wire        i_clk_en,
    input  wire        i_wr_en,
    input  wire        i_rd_en,
    input  wire [6:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire [2:0]  i_sync_mode,
    input  wire        i_sync_tick,
    input  wire        i_cmd_done,
    input  wire        i_crc_mismatch,
    input  wire        i_backup_fail,
    input  wire        i_selftest_fail,
    output reg  [7:0]  o_rdata,
    output reg         o_rd_valid,
    output wire        o_busy,
    output reg  [7:0]  o_cmd_pulse,
    output reg         o_soft_reset,
    output reg         o_sample_tick,
    output reg         o_output_tick,
    output wire        o_data_ready,
    output reg  [2:0]  o_diag_flags,
    output wire [5:0]  o_bias_enable,
    output wire [3:0]  o_time_base_exponent,
    output wire [10:0] o_output_decimation,
    output wire [15:0] o_scale_factor_value
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg  [15:0] scale_q;
reg  [15:0] decim_q;
reg  [15:0] bias_q;
reg  [7:0]  low_byte_q;
reg  [7:0]  pending_q;
reg  [31:0] base_cnt_q;
reg  [15:0] mult_cnt_q;
reg  [10:0] dec_cnt_q;
reg         ready_q;

wire [6:0]  even_addr = {i_addr[6:1], 1'b0};
wire        host_ok   = (pending_q == 8'h00);
wire        wr_ok     = i_wr_en & host_ok;

assign o_busy = ~host_ok;

// clamp so a value above the maximum cannot stretch the output period further
function [10:0] clamp_decim;
    input [15:0] v;
    begin
        if (v[`IRB_DECIM_MSB:0] > `IRB_DECIM_MAX) begin
            clamp_decim = `IRB_DECIM_MAX;
        end else begin
            clamp_decim = v[`IRB_DECIM_MSB:0];
        end
    end
endfunction

// the estimator only knows exponents up to twelve; larger stored values saturate
function [3:0] clamp_tbe;
    input [15:0] v;
    begin
        if (v[3:0] > `IRB_TBC_MAX) begin
            clamp_tbe = `IRB_TBC_MAX;
        end else begin
            clamp_tbe = v[3:0];
        end
    end
endfunction

// an accepted even-byte write to the command register starts a command
function cmd_write_hit;
    input       wr;
    input [6:0] addr;
    begin
        cmd_write_hit = wr & ~addr[0] & ({addr[6:1], 1'b0} == `IRB_ADDR_CMD);
    end
endfunction

function [7:0] byte_of;
    input [15:0] word;
    input        hi;
    begin
        byte_of = hi ? word[15:8] : word[7:0];
    end
endfunction

// one byte of the register map; command and unmapped addresses read as zero
function [7:0] read_byte;
    input [6:0]  addr;
    input [15:0] scale;
    input [15:0] decim;
    input [15:0] bias;
    begin
        case ({addr[6:1], 1'b0})
            `IRB_ADDR_SCALE: read_byte = byte_of(scale, addr[0]);
            `IRB_ADDR_DECIM: read_byte = byte_of(decim, addr[0]);
            `IRB_ADDR_BIAS:  read_byte = byte_of(bias, addr[0]);
            `IRB_ADDR_FWREV: read_byte = byte_of(FW_REVISION, addr[0]);  // see RL17
            default:         read_byte = 8'h00;
        endcase
    end
endfunction

assign o_output_decimation  = clamp_decim(decim_q);               // see RL1
assign o_bias_enable        = bias_q[13:8];                       // see RL6
assign o_time_base_exponent = clamp_tbe(bias_q);                  // see RL7
// direct and pulse modes multiply by one
assign o_scale_factor_value = (i_sync_mode == `IRB_MODE_SCALED) ?
                              scale_q : 16'h0001;                  // see RL5

////////////////////////////////////////////////////////////////////////////////
// host writes: low byte staged at even address, committed with high byte

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        scale_q     <= `IRB_RST_SCALE;
        decim_q     <= `IRB_RST_DECIM;
        bias_q      <= `IRB_RST_BIAS;                              // see RL8
        low_byte_q  <= 8'h00;
        pending_q   <= 8'h00;
        o_cmd_pulse <= 8'h00;
    end else if (i_clk_en) begin
        o_cmd_pulse <= 8'h00;
        if (o_soft_reset) begin
            // software reset restores the registers and pending commands; diagnostic flags keep their values
            scale_q    <= `IRB_RST_SCALE;                          // see RL11
            decim_q    <= `IRB_RST_DECIM;
            bias_q     <= `IRB_RST_BIAS;
            low_byte_q <= 8'h00;
            pending_q  <= 8'h00;
        end else if (!host_ok) begin
            if (i_cmd_done) begin
                if (pending_q[`IRB_CMD_RESTORE]) begin
                    decim_q <= `IRB_RST_DECIM;                     // see RL15
                end
                pending_q <= 8'h00;                                // see RL21
            end
        end else if (wr_ok) begin                                  // see RL10
            if (!i_addr[0]) begin
                low_byte_q <= i_wdata;                             // see RL20
                if (even_addr == `IRB_ADDR_CMD) begin
                    pending_q   <= i_wdata & 8'h9F;                // see RL9
                    o_cmd_pulse <= i_wdata & 8'h9F;
                end
            end else begin
                case (even_addr)
                    `IRB_ADDR_SCALE: scale_q <= {i_wdata, low_byte_q};
                    `IRB_ADDR_DECIM: decim_q <= {i_wdata, low_byte_q};
                    `IRB_ADDR_BIAS:  bias_q  <= {i_wdata, low_byte_q} & `IRB_BIAS_MASK;
                    default:         low_byte_q <= low_byte_q;
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// software reset pulse, in the same cycle as the command pulse

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_soft_reset <= 1'b0;
    end else if (i_clk_en) begin
        o_soft_reset <= cmd_write_hit(wr_ok, i_addr) & i_wdata[`IRB_CMD_RESET]
                        & ~o_soft_reset;                           // see RL11
    end
end

////////////////////////////////////////////////////////////////////////////////
// diagnostic results latched at completion; results come from the engines

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_diag_flags <= 3'b000;
    end else if (i_clk_en && !host_ok && i_cmd_done) begin
        if (pending_q[`IRB_CMD_FTEST]) begin
            o_diag_flags[2] <= i_crc_mismatch;                     // see RL12
        end
        if (pending_q[`IRB_CMD_SELFTEST]) begin
            o_diag_flags[1] <= i_selftest_fail;                    // see RL14
        end
        if (pending_q[`IRB_CMD_BACKUP]) begin
            o_diag_flags[0] <= i_backup_fail;                      // see RL13
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// reads: ignored while busy; command register reads as zero

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        o_rdata    <= 8'h00;
        o_rd_valid <= 1'b0;
    end else if (i_clk_en) begin
        o_rd_valid <= i_rd_en & host_ok;                           // see RL10
        if (i_rd_en && host_ok) begin
            o_rdata <= read_byte(i_addr, scale_q, decim_q, bias_q);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// sample clock: internal base, or sync ticks times the scale factor.
// scaled mode spreads k samples evenly by counting base periods divided by k
// would need a divider; instead the multiplier counts fast base ticks, which
// is exact only for the nominal 1 Hz / 2000 pairing (RL19 range is trusted).

wire scaled_mode = (i_sync_mode == `IRB_MODE_SCALED);
wire direct_mode = (i_sync_mode == `IRB_MODE_DIRECT) | (i_sync_mode == `IRB_MODE_PULSE);
wire base_hit    = (base_cnt_q == BASE_DIV - 32'd1);

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        base_cnt_q    <= 32'd0;
        mult_cnt_q    <= 16'h0000;
        o_sample_tick <= 1'b0;
    end else if (i_clk_en) begin
        base_cnt_q    <= base_hit ? 32'd0 : base_cnt_q + 32'd1;
        o_sample_tick <= 1'b0;
        if (!host_ok || o_soft_reset) begin
            mult_cnt_q <= 16'h0000;                                // see RL10
        end else if (scaled_mode) begin
            if (i_sync_tick) begin
                mult_cnt_q <= o_scale_factor_value;                // see RL4
            end else if (base_hit && mult_cnt_q != 16'h0000) begin
                mult_cnt_q    <= mult_cnt_q - 16'h0001;
                o_sample_tick <= 1'b1;                             // see RL19
            end
        end else if (direct_mode) begin
            o_sample_tick <= i_sync_tick;                          // see RL5
        end else begin
            o_sample_tick <= base_hit;                             // see RL2
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// decimation: one output per decimation+1 samples; the averaging engine
// uses o_output_tick as its period boundary

always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
        dec_cnt_q     <= 11'h000;
        o_output_tick <= 1'b0;
        ready_q       <= 1'b0;
    end else if (i_clk_en) begin
        o_output_tick <= 1'b0;
        if (!host_ok || o_soft_reset) begin
            dec_cnt_q <= 11'h000;
            ready_q   <= 1'b0;                                     // see RL10
        end else if (o_sample_tick) begin
            if (dec_cnt_q >= o_output_decimation) begin
                dec_cnt_q     <= 11'h000;
                o_output_tick <= 1'b1;                             // see RL3
                ready_q       <= 1'b1;
            end else begin
                dec_cnt_q <= dec_cnt_q + 11'h001;
                ready_q   <= 1'b0;
            end
        end
    end
end

assign o_data_ready = ready_q & host_ok;                           // see RL10

// bias update and restore of offsets act in the sensor path via o_cmd_pulse
// see RL16

endmodule

// ===== testbench/irb_host_model.sv
// host byte port driver plus a command engine that reports completion
// assumes one clock; requests change only just after a rising edge
`timescale 1ns/1ns
module irb_host_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_cmd_pulse,
    input  wire logic       i_fail,
    output logic            o_wr_en = 1'b0,
    output logic            o_rd_en = 1'b0,
    output logic [6:0]      o_addr = 7'h00,
    output logic [7:0]      o_wdata = 8'h00,
    output logic            o_cmd_done = 1'b0,
    output wire logic       o_crc_mismatch,
    output wire logic       o_backup_fail,
    output wire logic       o_selftest_fail
);
    logic [7:0] run_q = 8'h00;
    logic [5:0] cnt_q = 6'h00;
    // low byte to the even address first, high byte commits
    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        o_wr_en <= 1'b1;
        o_addr  <= a;
        o_wdata <= d[7:0];
        @(posedge i_ref_clk);
        o_addr  <= a + 7'h01;
        o_wdata <= d[15:8];
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d[15:8];
    endtask
    task automatic rd8(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge i_ref_clk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        @(negedge i_ref_clk);
        d = i_rdata;
        v = i_rd_valid;
    endtask
    task automatic rd16(input logic [6:0] a, output logic [15:0] d, output logic v);
        logic vl;
        rd8(a, d[7:0], vl);
        rd8(a + 7'h01, d[15:8], v);
        v = v & vl;
    endtask
    //////////////////////////////////////////////////////////////////
    // fixed 32-cycle run; results only hold while done is high
    always @(posedge i_ref_clk) begin
        o_cmd_done <= (cnt_q == 6'h01);
        if (i_cmd_pulse != 8'h00) begin
            run_q <= i_cmd_pulse;
            cnt_q <= 6'h20;
        end else if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
        end
    end
    assign o_crc_mismatch  = ~o_cmd_done ^ (i_fail & run_q[4]);
    assign o_backup_fail   = ~o_cmd_done ^ (i_fail & run_q[3]);
    assign o_selftest_fail = ~o_cmd_done ^ (i_fail & run_q[2]);
endmodule

// ===== testbench/irb_regs_asserts.sv
// port assertions for the rate, bias and command register group
// assumes the irb_regs top module; attached by the bind at the foot
`timescale 1ns/1ns
module irb_asserts (
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic        i_clk_en,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [6:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic [2:0]  i_sync_mode,
    input wire logic        i_cmd_done,
    input wire logic        o_rd_valid,
    input wire logic        o_busy,
    input wire logic [7:0]  o_cmd_pulse,
    input wire logic        o_soft_reset,
    input wire logic        o_data_ready,
    input wire logic [3:0]  o_time_base_exponent,
    input wire logic [10:0] o_output_decimation,
    input wire logic [15:0] o_scale_factor_value
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    wire take = i_clk_en & !o_busy;
    // bits 6:5 of the command byte are unused and never start anything
    wire cmdw = take & i_wr_en & (i_addr == 7'h68) & ((i_wdata & 8'h9F) != 8'h00);
    //////////////////////////////////////////////////////////////////
    a_cmd_starts:
    assert property (cmdw |=> o_busy && o_cmd_pulse == ($past(i_wdata) & 8'h9F)) else $error("bad start");
    a_soft_rst_tie:
    assert property (o_soft_reset |-> o_cmd_pulse[7]) else $error("stray soft reset");
    a_busy_quiet:
    assert property (o_busy |-> !o_data_ready) else $error("ready while busy");
    a_busy_refuse:
    assert property (o_busy && i_rd_en |=> !o_rd_valid) else $error("read served while busy");
    a_read_answer:
    assert property (take && i_rd_en |=> o_rd_valid) else $error("read not answered");
    a_done_clears:
    assert property (o_busy && i_cmd_done && i_clk_en |=> !o_busy) else $error("busy stuck");
    a_decim_cap:
    assert property (o_output_decimation <= 11'h7CF) else $error("decimation above cap");
    a_tbe_cap:
    assert property (o_time_base_exponent <= 4'hC) else $error("exponent above cap");
    a_scale_unity:
    assert property ((i_sync_mode == 3'h1 || i_sync_mode == 3'h5) [*2] |->
                     o_scale_factor_value == 16'h0001) else $error("scale not one");
    c_cmd: cover property (cmdw);
    c_srst: cover property (o_soft_reset);
    c_refuse: cover property (o_busy && i_rd_en);
endmodule
bind irb_regs irb_asserts chk (.*);

// ===== testbench/tb.sv
// self-checking bench for the rate, bias and command register group
// assumes the host model drives the byte port; base divider shortened
`timescale 1ns/1ns
module tb;
    localparam logic [15:0] FW = 16'h0104; // arbitrary value
    logic        i_ref_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_clk_en = 1'b1;
    logic        i_sync_tick = 1'b0;
    logic [2:0]  i_sync_mode = 3'h0;
    logic        fail = 1'b0;
    logic        i_wr_en, i_rd_en, i_cmd_done, i_crc_mismatch, i_backup_fail, i_selftest_fail;
    logic [6:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, o_cmd_pulse;
    logic        o_rd_valid, o_busy, o_soft_reset, o_sample_tick, o_output_tick, o_data_ready;
    logic [2:0]  o_diag_flags;
    logic [5:0]  o_bias_enable;
    logic [3:0]  o_time_base_exponent;
    logic [10:0] o_output_decimation;
    logic [15:0] o_scale_factor_value;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    irb_regs #(.FW_REVISION(FW), .BASE_DIV(32'd10)) dut (.*);
    irb_host_model host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid),
        .i_cmd_pulse(o_cmd_pulse), .i_fail(fail), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata), .o_cmd_done(i_cmd_done),
        .o_crc_mismatch(i_crc_mismatch), .o_backup_fail(i_backup_fail),
        .o_selftest_fail(i_selftest_fail));
    always #10 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    //////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        host.rd16(a, d, v);
        chk(d, e);
        chk(16'(v), 16'h0001);
    endtask
    task t_reset_values;
        rd_chk(7'h62, 16'h07D0);
        rd_chk(7'h64, 16'h0000);
        rd_chk(7'h66, 16'h070A);
        rd_chk(7'h6C, FW);
        rd_chk(7'h68, 16'h0000);
        rd_chk(7'h50, 16'h0000);
        chk(16'(o_bias_enable), 16'h0007);
        chk(16'(o_time_base_exponent), 16'h000A);
    endtask
    task automatic pulse_count(output int n);
        n = 0;
        i_sync_tick <= 1'b1;
        @(posedge i_ref_clk);
        i_sync_tick <= 1'b0;
        repeat (60) begin
            @(negedge i_ref_clk);
            if (o_sample_tick === 1'b1) n++;
        end
        @(posedge i_ref_clk);
    endtask
    task t_decim;
        int n;
        int r;
        n = 0;
        r = 0;
        host.wr16(7'h64, 16'h0013);
        rd_chk(7'h64, 16'h0013);
        chk(16'(o_output_decimation), 16'h0013);
        host.wr16(7'h64, 16'h0001);
        repeat (400) begin
            @(negedge i_ref_clk);
            if (o_output_tick === 1'b1) n++;
            if (o_data_ready === 1'b1) r++;
        end
        chk(16'(n >= 19 && n <= 21), 16'h0001);
        chk(16'(r >= 180 && r <= 220), 16'h0001);
        host.wr16(7'h64, 16'hFFFF);
        @(negedge i_ref_clk);
        chk(16'(o_output_decimation), 16'h07CF);
    endtask
    task t_bias;
        host.wr16(7'h66, 16'hFFFF);
        rd_chk(7'h66, 16'h3F0F);
        chk(16'(o_bias_enable), 16'h003F);
        chk(16'(o_time_base_exponent), 16'h000C);
        host.wr16(7'h66, 16'h0105);
        @(negedge i_ref_clk);
        chk({o_bias_enable, o_time_base_exponent}, 16'h0015);
        @(posedge i_ref_clk);
        i_clk_en <= 1'b0;
        host.wr16(7'h66, 16'h0000);
        i_clk_en <= 1'b1;
        rd_chk(7'h66, 16'h0105);
    endtask
    task t_scale;
        int n;
        host.wr16(7'h62, 16'h0003);
        i_sync_mode <= 3'h1;
        repeat (3) @(posedge i_ref_clk);
        chk(o_scale_factor_value, 16'h0001);
        pulse_count(n);
        chk(16'(n), 16'h0001);
        i_sync_mode <= 3'h5;
        repeat (3) @(posedge i_ref_clk);
        chk(o_scale_factor_value, 16'h0001);
        pulse_count(n);
        chk(16'(n), 16'h0001);
        i_sync_mode <= 3'h2;
        repeat (3) @(posedge i_ref_clk);
        chk(o_scale_factor_value, 16'h0003);
        pulse_count(n);
        chk(16'(n), 16'h0003);
        i_sync_mode <= 3'h0;
    endtask
    task t_cmds;
        int b;
        logic [15:0] d;
        logic        v;
        for (int k = 0; k < 6; k++) begin
            b = (k == 5) ? 7 : 4 - k;
            fail <= (b != 3);
            if (b == 1 || b == 7) host.wr16(7'h64, 16'h0005);
            host.wr16(7'h68, 16'(1 << b));
            if (b != 7) begin
                chk(16'(o_busy), 16'h0001);
                host.rd16(7'h64, d, v);
                chk(16'(v), 16'h0000);
            end
            repeat (100) if (o_busy !== 1'b0) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            chk(16'(o_busy), 16'h0000);
            if (b == 4) chk(16'(o_diag_flags[2]), 16'h0001);
            if (b == 3) chk(16'(o_diag_flags[0]), 16'h0000);
            if (b == 2) chk(16'(o_diag_flags[1]), 16'h0001);
            if (b == 1) rd_chk(7'h64, 16'h0000);
            if (b == 7) rd_chk(7'h64, 16'h0000);
        end
    endtask
    task final_report;
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_reset_values();
        t_decim();
        t_bias();
        t_scale();
        t_cmds();
        final_report();
    end
endmodule
